//--- inc/smod_pkg.sv
// Shared constants and types for the spread-modem register port and buffer
package smod_pkg;
   localparam int BUF_DEPTH = 256;
   localparam int PTR_W = 8;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int FRAME_W = 16;
   localparam int FRAME_BITS = 16;
   localparam int CARRIER_W = 24;
   localparam int IF_W = 16;
   localparam int FSTEP_SHIFT = 19;
   // Link clock divider: 200 MHz / (2 * 8) = 12.5 MHz, 80 ns period
   localparam int SCK_HALF = 8;
   localparam logic [3:0] SCK_HALF_M1 = 4'h7;
   // Device register addresses on the serial port
   localparam logic [ADDR_W-1:0] A_DATA = 7'h00;
   localparam logic [ADDR_W-1:0] A_OPMODE = 7'h01;
   localparam logic [ADDR_W-1:0] A_CARRIER_H = 7'h06;
   localparam logic [ADDR_W-1:0] A_CARRIER_M = 7'h07;
   localparam logic [ADDR_W-1:0] A_CARRIER_L = 7'h08;
   localparam logic [ADDR_W-1:0] A_ACCESS_PTR = 7'h0D;
   localparam logic [ADDR_W-1:0] A_TX_BASE = 7'h0E;
   localparam logic [ADDR_W-1:0] A_RX_BASE = 7'h0F;
   localparam logic [ADDR_W-1:0] A_RX_CURRENT = 7'h10;
   localparam logic [ADDR_W-1:0] A_IRQ_FLAGS = 7'h12;
   localparam logic [ADDR_W-1:0] A_RX_COUNT = 7'h13;
   localparam logic [ADDR_W-1:0] A_HDR_MODE = 7'h1D;
   localparam logic [ADDR_W-1:0] A_PAYLOAD = 7'h22;
   localparam logic [ADDR_W-1:0] A_IF_H = 7'h2F;
   localparam logic [ADDR_W-1:0] A_IF_L = 7'h30;
   // Operating mode register fields
   localparam int SELECT_BIT = 7;
   localparam logic [2:0] MODE_SLEEP = 3'h0;
   localparam logic [2:0] MODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_TX_SYNTH = 3'h2;
   localparam logic [2:0] MODE_TX = 3'h3;
   localparam logic [2:0] MODE_RX_SYNTH = 3'h4;
   localparam logic [2:0] MODE_RX_CONT = 3'h5;
   localparam logic [2:0] MODE_RX_SINGLE = 3'h6;
   localparam int TX_DONE_BIT = 3;
   localparam int RX_DONE_BIT = 6;
   localparam int IMPLICIT_BIT = 0;
   localparam logic [7:0] OPMODE_RST = 8'h01;
   localparam logic [7:0] PAYLOAD_RST = 8'h01;
   // Host APB register map
   localparam logic [7:0] R_CMD = 8'h00;
   localparam logic [7:0] R_WDATA = 8'h04;
   localparam logic [7:0] R_STATUS = 8'h08;
   localparam logic [7:0] R_RDATA = 8'h0C;
   localparam int CMD_WRITE_BIT = 8;
   localparam int CMD_GO_BIT = 9;
endpackage

//--- inc/smod_if.sv
// Serial register port between host controller and modem
`timescale 1ns/10ps
interface smod_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   modport modem (input sck, input cs_n, input mosi, output miso);
   modport ctrl (output sck, output cs_n, output mosi, input miso);
endinterface

//--- design/smod_modem.sv
// Modem end: serial register port, mode control, packet buffer and pointers
// What this block does
// - Configuration registers readable in every mode
// - Host writes configuration in any mode, not only sleep/standby
// - Configuration kept during FSK/OOK mode
// - Status readable except in sleep
// - Status cleared on each receive entry
// - 256-byte shared transmit/receive buffer
// - Transmit fetch and receive store from bases
// - Data port access at pointer, then increment
// - Host loads access pointer before buffer access
// - Payload size drives transmit; count reports receive
// - Explicit header length sizes receive
// - Equal bases let whole buffer serve
// - Buffer lost and inaccessible in sleep
// - Select bit changes only in sleep
// - Standby runs oscillator; synth modes add PLL
// - Transmit sends packet, flags done, back standby
// - Continuous receive runs until mode change
// - Single receive ends after one packet
// - Carrier is 24-bit word times step
// - IF word used only in receive
// - Host programs IF from bandwidth
// - Host fills buffer in standby first
`timescale 1ns/10ps
module smod_modem
   import smod_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Serial register port
   smod_if.modem port,
   // Radio datapath: received bytes
   input wire logic rx_byte_valid,
   input wire logic [DATA_W-1:0] rx_byte,
   input wire logic rx_hdr_valid,
   input wire logic [DATA_W-1:0] rx_hdr_len,
   input wire logic rx_packet_end,
   // Radio datapath: transmitted bytes
   output logic tx_byte_valid,
   output logic [DATA_W-1:0] tx_byte,
   input wire logic tx_byte_ready,
   // Power and frequency controls
   output logic xosc_on,
   output logic pll_on,
   output logic pll_rx,
   output logic [CARRIER_W-1:0] carrier_word,
   output logic [IF_W-1:0] if_word,
   output logic modem_active
);
   logic [2:0] sck_s_ff, cs_s_ff, mosi_s_ff;
   logic [4:0] bitcnt_ff;
   logic [FRAME_W-1:0] shin_ff;
   logic [FRAME_W-1:0] shin_nxt;
   logic wr_done_ff;
   logic [DATA_W-1:0] rd_buf_ff;
   logic [DATA_W-1:0] shout_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic wr_ff;
   logic [DATA_W-1:0] mem_ff [BUF_DEPTH];
   logic [PTR_W-1:0] access_ptr_ff, tx_base_ff, rx_base_ff, rx_cur_ff, tx_rd_ff;
   logic [DATA_W-1:0] opmode_ff, payload_ff, rx_count_ff, irq_ff, rx_len_ff, hdr_ff;
   logic [CARRIER_W-1:0] carrier_ff;
   logic [IF_W-1:0] if_ff;
   logic [DATA_W-1:0] tx_left_ff;
   logic tx_byte_valid_ff;
   logic sck_rise, sck_fall, sel, wr_done, rd_start, data_rd, data_wr;
   logic [DATA_W-1:0] rd_val;
   logic [2:0] mode;
   logic sleeping, rx_mode, entering_rx, rx_in_len;

   assign mode = opmode_ff[2:0];
   assign sleeping = (mode == MODE_SLEEP);
   assign rx_mode = (mode == MODE_RX_CONT) || (mode == MODE_RX_SINGLE);

   // Pins pass three flops; only stages 1 and 2 are looked at by logic
   always_ff @(posedge mclk) begin
      if (srst) begin
         sck_s_ff <= 3'h0;
         cs_s_ff <= 3'h7;
         mosi_s_ff <= 3'h0;
      end else begin
         sck_s_ff <= {sck_s_ff[1:0], port.sck};
         cs_s_ff <= {cs_s_ff[1:0], port.cs_n};
         mosi_s_ff <= {mosi_s_ff[1:0], port.mosi};
      end
   end
   assign sel = !cs_s_ff[1];
   assign sck_rise = sel && sck_s_ff[1] && !sck_s_ff[2];
   assign sck_fall = sel && !sck_s_ff[1] && sck_s_ff[2];
   // Shift register value including the bit arriving on this rise
   assign shin_nxt = {shin_ff[FRAME_W-2:0], mosi_s_ff[1]};

   // Frame: write bit, 7 address bits, 8 data bits, MSB first
   always_ff @(posedge mclk) begin
      if (srst || !sel) begin
         bitcnt_ff <= 5'h00;
         shin_ff <= '0;
      end else if (sck_rise) begin
         bitcnt_ff <= bitcnt_ff + 5'h01;
         shin_ff <= shin_nxt;
      end
   end
   assign rd_start = sck_rise && (bitcnt_ff == 5'h07);
   // Write applied one cycle after the last rise, once all 16 bits are held
   always_ff @(posedge mclk) begin
      if (srst) wr_done_ff <= 1'b0;
      else wr_done_ff <= sck_rise && (bitcnt_ff == 5'h0F);
   end
   assign wr_done = wr_done_ff && wr_ff;
   always_ff @(posedge mclk) begin
      if (srst) begin
         addr_ff <= '0;
         wr_ff <= 1'b0;
      end else if (rd_start) begin
         addr_ff <= shin_nxt[ADDR_W-1:0];
         wr_ff <= shin_nxt[ADDR_W];
      end
   end

   function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
      read_mux = '0;
      unique case (a)
         A_DATA: read_mux = sleeping ? '0 : mem_ff[access_ptr_ff];
         A_OPMODE: read_mux = opmode_ff;
         A_CARRIER_H: read_mux = carrier_ff[23:16];
         A_CARRIER_M: read_mux = carrier_ff[15:8];
         A_CARRIER_L: read_mux = carrier_ff[7:0];
         A_ACCESS_PTR: read_mux = access_ptr_ff;
         A_TX_BASE: read_mux = tx_base_ff;
         A_RX_BASE: read_mux = rx_base_ff;
         A_RX_CURRENT: read_mux = sleeping ? '0 : rx_cur_ff;
         A_IRQ_FLAGS: read_mux = sleeping ? '0 : irq_ff;
         A_RX_COUNT: read_mux = sleeping ? '0 : rx_count_ff;
         A_HDR_MODE: read_mux = hdr_ff;
         A_PAYLOAD: read_mux = payload_ff;
         A_IF_H: read_mux = if_ff[15:8];
         A_IF_L: read_mux = if_ff[7:0];
         default: read_mux = '0;
      endcase
   endfunction

   assign rd_val = read_mux(shin_nxt[ADDR_W-1:0]);
   assign data_rd = rd_start && !shin_nxt[ADDR_W] && (shin_nxt[ADDR_W-1:0] == A_DATA) && !sleeping;
   assign data_wr = wr_done && (addr_ff == A_DATA) && !sleeping;

   // Read value captured at the address phase, put on the pin only at a fall
   always_ff @(posedge mclk) begin
      if (srst) rd_buf_ff <= '0;
      else if (rd_start) rd_buf_ff <= shin_nxt[ADDR_W] ? '0 : rd_val;
   end

   // Read data shifted out on falling edges
   always_ff @(posedge mclk) begin
      if (srst || !sel) begin
         shout_ff <= '0;
      end else if (sck_fall && bitcnt_ff == 5'h08) begin
         shout_ff <= rd_buf_ff;
      end else if (sck_fall && bitcnt_ff > 5'h08) begin
         shout_ff <= {shout_ff[DATA_W-2:0], 1'b0};
      end
   end
   assign port.miso = shout_ff[DATA_W-1];

   // Configuration writes; contents kept whichever modem is selected
   always_ff @(posedge mclk) begin
      if (srst) begin
         opmode_ff <= OPMODE_RST;
         payload_ff <= PAYLOAD_RST;
         carrier_ff <= '0;
         if_ff <= '0;
         tx_base_ff <= '0;
         rx_base_ff <= '0;
         hdr_ff <= '0;
      end else begin
         if (wr_done) begin
            unique case (addr_ff)
               A_OPMODE: begin
                  // Select bit only moves while asleep
                  opmode_ff[2:0] <= shin_ff[2:0];
                  opmode_ff[6:3] <= shin_ff[6:3];
                  if (sleeping) opmode_ff[SELECT_BIT] <= shin_ff[SELECT_BIT];
               end
               A_CARRIER_H: carrier_ff[23:16] <= shin_ff[7:0];
               A_CARRIER_M: carrier_ff[15:8] <= shin_ff[7:0];
               A_CARRIER_L: carrier_ff[7:0] <= shin_ff[7:0];
               A_TX_BASE: tx_base_ff <= shin_ff[7:0];
               A_RX_BASE: rx_base_ff <= shin_ff[7:0];
               A_HDR_MODE: hdr_ff <= shin_ff[7:0];
               A_PAYLOAD: payload_ff <= shin_ff[7:0];
               A_IF_H: if_ff[15:8] <= shin_ff[7:0];
               A_IF_L: if_ff[7:0] <= shin_ff[7:0];
               default: ;
            endcase
         end
         // Transmit and single receive drop back to standby
         if (mode == MODE_TX && tx_left_ff == '0 && !tx_byte_valid_ff && !wr_done)
            opmode_ff[2:0] <= MODE_STANDBY;
         if (mode == MODE_RX_SINGLE && rx_packet_end && !wr_done)
            opmode_ff[2:0] <= MODE_STANDBY;
      end
   end

   // Access pointer, 8 bits so it wraps
   always_ff @(posedge mclk) begin
      if (srst) access_ptr_ff <= '0;
      else if (wr_done && addr_ff == A_ACCESS_PTR) access_ptr_ff <= shin_ff[7:0];
      else if (data_rd || data_wr) access_ptr_ff <= access_ptr_ff + 8'h01;
   end

   // Transmit fetch counter
   logic tx_start;
   assign tx_start = wr_done && addr_ff == A_OPMODE && shin_ff[2:0] == MODE_TX && mode != MODE_TX;
   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_left_ff <= '0;
         tx_rd_ff <= '0;
         tx_byte_valid_ff <= 1'b0;
         tx_byte <= '0;
      end else if (tx_start) begin
         tx_left_ff <= payload_ff;
         tx_rd_ff <= tx_base_ff;
         tx_byte_valid_ff <= 1'b0;
      end else if (mode == MODE_TX) begin
         if (tx_byte_valid_ff && tx_byte_ready) tx_byte_valid_ff <= 1'b0;
         else if (!tx_byte_valid_ff && tx_left_ff != '0) begin
            tx_byte <= mem_ff[tx_rd_ff];
            tx_byte_valid_ff <= 1'b1;
            tx_rd_ff <= tx_rd_ff + 8'h01;
            tx_left_ff <= tx_left_ff - 8'h01;
         end
      end else begin
         tx_byte_valid_ff <= 1'b0;
      end
   end
   assign tx_byte_valid = tx_byte_valid_ff;

   // Receive store, length and status
   assign entering_rx = wr_done && addr_ff == A_OPMODE && !rx_mode &&
      (shin_ff[2:0] == MODE_RX_CONT || shin_ff[2:0] == MODE_RX_SINGLE);
   assign rx_in_len = hdr_ff[IMPLICIT_BIT] ? (rx_count_ff < payload_ff) : (rx_count_ff < rx_len_ff);
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_cur_ff <= '0;
         rx_count_ff <= '0;
         rx_len_ff <= '0;
      end else if (entering_rx) begin
         rx_cur_ff <= rx_base_ff;
         rx_count_ff <= '0;
         rx_len_ff <= '0;
      end else if (rx_mode) begin
         if (rx_hdr_valid) begin
            rx_len_ff <= rx_hdr_len;
            rx_count_ff <= '0;
         end else if (rx_byte_valid && rx_in_len) begin
            rx_cur_ff <= rx_cur_ff + 8'h01;
            rx_count_ff <= rx_count_ff + 8'h01;
         end
      end
   end

   // Event flags: write one clears, hardware set wins
   always_ff @(posedge mclk) begin
      if (srst) irq_ff <= '0;
      else begin
         if (entering_rx) irq_ff <= '0;
         else if (wr_done && addr_ff == A_IRQ_FLAGS) irq_ff <= irq_ff & ~shin_ff[7:0];
         if (mode == MODE_TX && tx_left_ff == '0 && !tx_byte_valid_ff && !tx_start)
            irq_ff[TX_DONE_BIT] <= 1'b1;
         if (rx_mode && rx_packet_end) irq_ff[RX_DONE_BIT] <= 1'b1;
      end
   end

   // Buffer storage; cleared when sleep is entered
   genvar gi;
   for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_mem
      always_ff @(posedge mclk) begin
         if (srst || sleeping) mem_ff[gi] <= '0;
         else if (data_wr && access_ptr_ff == PTR_W'(gi)) mem_ff[gi] <= shin_ff[7:0];
         else if (rx_mode && !rx_hdr_valid && rx_byte_valid && rx_in_len &&
            rx_cur_ff == PTR_W'(gi)) mem_ff[gi] <= rx_byte;
      end
   end

   // Power and synthesiser controls
   always_ff @(posedge mclk) begin
      if (srst) begin
         xosc_on <= 1'b0;
         pll_on <= 1'b0;
         pll_rx <= 1'b0;
         carrier_word <= '0;
         if_word <= '0;
         modem_active <= 1'b0;
      end else begin
         xosc_on <= !sleeping;
         pll_on <= !sleeping && mode != MODE_STANDBY;
         pll_rx <= (mode == MODE_RX_SYNTH) || rx_mode;
         carrier_word <= carrier_ff;
         if_word <= rx_mode || mode == MODE_RX_SYNTH ? if_ff : '0;
         modem_active <= opmode_ff[SELECT_BIT];
      end
   end
endmodule

//--- design/smod_ctrl.sv
// Host end: APB-programmed serial register port master
`timescale 1ns/10ps
module smod_ctrl
   import smod_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial register port
   smod_if.ctrl port
);
   typedef enum logic [1:0] {IDLE, SHIFT, DONE} st_t;
   st_t st_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic wr_ff, busy;
   logic [DATA_W-1:0] wdata_ff, rdata_ff;
   logic [FRAME_W-1:0] sh_ff;
   logic [4:0] bits_ff;
   logic [3:0] div_ff;
   logic sck_ff, cs_n_ff;
   logic [1:0] miso_s_ff;
   logic acc, go, tick;

   assign acc = psel && penable;
   assign pready = 1'b1;
   assign busy = (st_ff != IDLE);
   assign go = acc && pwrite && paddr == R_CMD && pwdata[CMD_GO_BIT] && !busy;
   assign pslverr = acc && !(paddr == R_CMD || paddr == R_WDATA ||
      paddr == R_STATUS || paddr == R_RDATA);
   assign tick = (div_ff == SCK_HALF_M1);

   always_ff @(posedge mclk) begin
      if (srst) begin
         addr_ff <= '0;
         wr_ff <= 1'b0;
         wdata_ff <= '0;
      end else if (acc && pwrite && paddr == R_WDATA) begin
         wdata_ff <= pwdata[7:0];
      end else if (go) begin
         addr_ff <= pwdata[ADDR_W-1:0];
         wr_ff <= pwdata[CMD_WRITE_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) prdata <= '0;
      else if (psel && !penable) begin
         unique case (paddr)
            R_CMD: prdata <= {23'h0, wr_ff, 1'b0, addr_ff};
            R_WDATA: prdata <= {24'h0, wdata_ff};
            R_STATUS: prdata <= {31'h0, busy};
            R_RDATA: prdata <= {24'h0, rdata_ff};
            default: prdata <= '0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) miso_s_ff <= 2'h0;
      else miso_s_ff <= {miso_s_ff[0], port.miso};
   end

   // Frame engine: sck idles low, data changes on falling, sampled on rising
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_ff <= IDLE;
         div_ff <= '0;
         sck_ff <= 1'b0;
         cs_n_ff <= 1'b1;
         sh_ff <= '0;
         bits_ff <= '0;
         rdata_ff <= '0;
      end else begin
         unique case (st_ff)
            IDLE: begin
               div_ff <= '0;
               if (go) begin
                  st_ff <= SHIFT;
                  cs_n_ff <= 1'b0;
                  sh_ff <= {pwdata[CMD_WRITE_BIT], pwdata[ADDR_W-1:0], wdata_ff};
                  bits_ff <= '0;
               end
            end
            SHIFT: begin
               div_ff <= tick ? 4'h0 : div_ff + 4'h1;
               if (tick) begin
                  sck_ff <= !sck_ff;
                  if (sck_ff) begin
                     sh_ff <= {sh_ff[FRAME_W-2:0], 1'b0};
                     if (bits_ff == 5'(FRAME_BITS)) st_ff <= DONE;
                  end else begin
                     bits_ff <= bits_ff + 5'h01;
                     rdata_ff <= {rdata_ff[DATA_W-2:0], miso_s_ff[1]};
                  end
               end
            end
            DONE: begin
               div_ff <= tick ? 4'h0 : div_ff + 4'h1;
               if (tick) begin
                  cs_n_ff <= 1'b1;
                  st_ff <= IDLE;
               end
            end
            default: st_ff <= IDLE;
         endcase
      end
   end
   assign port.sck = sck_ff;
   assign port.cs_n = cs_n_ff;
   assign port.mosi = sh_ff[FRAME_W-1];
endmodule

//--- bench/smod_checker.sv
// Wire-level checks on the serial register port between the two ends
`timescale 1ns/10ps
module smod_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Serial port
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   logic sck_q_ff;
   logic [5:0] rise_cnt_ff;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   always_ff @(posedge mclk) begin
      sck_q_ff <= sck;
   end

   // Counts link clock rises inside one frame
   always_ff @(posedge mclk) begin
      if (srst || cs_n) begin
         rise_cnt_ff <= 6'h00;
      end else if (sck && !sck_q_ff) begin
         rise_cnt_ff <= rise_cnt_ff + 6'h01;
      end
   end

   property p_idle_low;
      cs_n |-> !sck;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("link clock not idle low");

   property p_sck_high;
      $rose(sck) |-> sck [*8] ##1 !sck;
   endproperty
   a_sck_high: assert property (p_sck_high) else $error("link clock high phase wrong");

   property p_sck_low;
      $fell(sck) |-> (!sck) [*8];
   endproperty
   a_sck_low: assert property (p_sck_low) else $error("link clock low phase short");

   property p_mosi_hold;
      sck && $past(sck) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while clock high");

   property p_miso_hold;
      !cs_n && sck && $past(sck) |-> $stable(miso);
   endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved while clock high");

   property p_frame_bits;
      $rose(cs_n) |-> rise_cnt_ff == 6'h10;
   endproperty
   a_frame_bits: assert property (p_frame_bits) else $error("frame not 16 clock pulses");

   property p_gap;
      $rose(cs_n) |-> cs_n [*2];
   endproperty
   a_gap: assert property (p_gap) else $error("select gap too short");

   property p_frame_len;
      $fell(cs_n) |-> ##[240:400] $rose(cs_n);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length out of range");

   c_frame: cover property ($rose(cs_n) && rise_cnt_ff == 6'h10);
   c_read_one: cover property (!cs_n && miso);
   c_write_bit: cover property ($fell(cs_n) ##[1:20] (mosi && sck));
endmodule

//--- bench/testbench.sv
// Bench: APB host end talking to the modem end over the serial port
`timescale 1ns/10ps
module testbench;
   import smod_pkg::*;
   logic mclk, srst, psel, penable, pwrite, pready, pslverr, apb_e;
   logic [7:0] paddr, rd;
   logic [31:0] pwdata, prdata, apb_r;
   logic rx_byte_valid, rx_hdr_valid, rx_packet_end, tx_byte_valid, tx_byte_ready;
   logic [7:0] rx_byte, rx_hdr_len, tx_byte;
   logic xosc_on, pll_on, pll_rx, modem_active;
   logic [23:0] carrier_word;
   logic [15:0] if_word;
   logic [7:0] txq[$];
   logic [2:0] mode_tab[3] = '{MODE_STANDBY, MODE_TX_SYNTH, MODE_RX_SYNTH};
   logic [2:0] pwr_tab[3] = '{3'h4, 3'h6, 3'h7};
   int err_count = 0;
   int n_compared = 0;

   smod_if port_if ();
   smod_ctrl smod_ctrl_i (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port(port_if));
   smod_modem smod_modem_i (.mclk(mclk), .srst(srst), .port(port_if),
      .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_hdr_valid(rx_hdr_valid),
      .rx_hdr_len(rx_hdr_len), .rx_packet_end(rx_packet_end), .tx_byte_valid(tx_byte_valid),
      .tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready), .xosc_on(xosc_on), .pll_on(pll_on),
      .pll_rx(pll_rx), .carrier_word(carrier_word), .if_word(if_word),
      .modem_active(modem_active));
   smod_checker smod_checker_i (.mclk(mclk), .srst(srst), .sck(port_if.sck),
      .cs_n(port_if.cs_n), .mosi(port_if.mosi), .miso(port_if.miso));

   always #2.5 mclk = ~mclk;

   // Radio sink stalls every other cycle
   always @(posedge mclk) begin
      tx_byte_ready <= ~tx_byte_ready;
      if (tx_byte_valid === 1'b1 && tx_byte_ready === 1'b1) begin
         txq.push_back(tx_byte);
      end
   end

   task automatic stop_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (n > 50) begin
            err_count++;
            $display("MISMATCH %0t no APB answer", $time);
            stop_test();
         end
      end while (pready !== 1'b1);
      apb_r = prdata;
      apb_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One serial frame: load data, launch, poll busy, fetch read data
   task automatic dev(input logic wr, input logic [6:0] a, input logic [7:0] d);
      int n;
      apb(1'b1, R_WDATA, {24'h000000, d});
      apb(1'b1, R_CMD, {22'h000000, 1'b1, wr, 1'b0, a});
      n = 0;
      do begin
         apb(1'b0, R_STATUS, 32'h00000000);
         n++;
         if (n > 200) begin
            err_count++;
            $display("MISMATCH %0t frame never finished", $time);
            stop_test();
         end
      end while (apb_r[0] !== 1'b0);
      if (!wr) begin
         apb(1'b0, R_RDATA, 32'h00000000);
         rd = apb_r[7:0];
      end
   endtask

   task automatic w(input logic [6:0] a, input logic [7:0] d);
      dev(1'b1, a, d);
   endtask

   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      dev(1'b0, a, 8'h00);
      check({24'h000000, rd}, {24'h000000, e});
   endtask

   task automatic rx_pkt(input logic [7:0] len, input logic [7:0] b0);
      @(posedge mclk);
      rx_hdr_valid <= 1'b1;
      rx_hdr_len <= len;
      @(posedge mclk);
      rx_hdr_valid <= 1'b0;
      for (int i = 0; i < int'(len); i++) begin
         @(posedge mclk);
         rx_byte_valid <= 1'b1;
         rx_byte <= b0 + 8'(i);
         @(posedge mclk);
         rx_byte_valid <= 1'b0;
      end
      @(posedge mclk);
      rx_packet_end <= 1'b1;
      @(posedge mclk);
      rx_packet_end <= 1'b0;
   endtask

   initial begin
      mclk = 1'b0;
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      rx_byte_valid = 1'b0;
      rx_hdr_valid = 1'b0;
      rx_packet_end = 1'b0;
      rx_byte = 8'h00;
      rx_hdr_len = 8'h00;
      tx_byte_ready = 1'b0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      rc(A_OPMODE, OPMODE_RST);
      rc(A_PAYLOAD, PAYLOAD_RST);
      w(A_OPMODE, 8'h00);
      w(A_OPMODE, 8'h80);
      rc(A_OPMODE, 8'h80);
      w(A_CARRIER_H, 8'h12);
      w(A_CARRIER_M, 8'h34);
      w(A_CARRIER_L, 8'h56);
      rc(A_CARRIER_H, 8'h12);
      check({8'h00, carrier_word}, 32'h00123456);
      w(A_DATA, 8'hAA);
      rc(A_DATA, 8'h00);
      w(A_IF_H, 8'h0A);
      w(A_IF_L, 8'hB0);
      w(A_OPMODE, 8'h00);
      rc(A_IF_L, 8'hB0);
      rc(A_CARRIER_L, 8'h56);
      w(A_OPMODE, 8'h80);
      w(A_OPMODE, 8'h81);
      w(A_OPMODE, 8'h01);
      rc(A_OPMODE, 8'h81);
      for (int i = 0; i < 3; i++) begin
         w(A_OPMODE, {5'h10, mode_tab[i]});
         check({29'h0, xosc_on, pll_on, pll_rx}, {29'h0, pwr_tab[i]});
      end
      w(A_OPMODE, 8'h81);
      w(A_TX_BASE, 8'hFE);
      w(A_PAYLOAD, 8'h03);
      w(A_ACCESS_PTR, 8'hFE);
      for (int i = 0; i < 3; i++) begin
         w(A_DATA, 8'h11 * 8'(i + 1));
      end
      rc(A_ACCESS_PTR, 8'h01);
      w(A_ACCESS_PTR, 8'hFE);
      for (int i = 0; i < 3; i++) begin
         rc(A_DATA, 8'h11 * 8'(i + 1));
      end
      w(A_OPMODE, 8'h83);
      rc(A_OPMODE, 8'h81);
      check(32'(txq.size()), 32'h00000003);
      for (int i = 0; i < 3; i++) begin
         check({24'h0, txq[i]}, {24'h0, 8'h11 * 8'(i + 1)});
      end
      rc(A_IRQ_FLAGS, 8'h08);
      w(A_RX_BASE, 8'hFE);
      w(A_OPMODE, 8'h86);
      rc(A_IRQ_FLAGS, 8'h00);
      rx_pkt(8'h02, 8'hA1);
      rc(A_OPMODE, 8'h81);
      rc(A_RX_COUNT, 8'h02);
      rc(A_IRQ_FLAGS, 8'h40);
      w(A_ACCESS_PTR, 8'hFE);
      rc(A_DATA, 8'hA1);
      rc(A_DATA, 8'hA2);
      w(A_OPMODE, 8'h85);
      rx_pkt(8'h01, 8'hB1);
      rc(A_OPMODE, 8'h85);
      rc(A_RX_COUNT, 8'h01);
      w(A_OPMODE, 8'h80);
      rc(A_RX_COUNT, 8'h00);
      w(A_OPMODE, 8'h81);
      w(A_ACCESS_PTR, 8'hFE);
      rc(A_DATA, 8'h00);
      apb(1'b0, 8'h40, 32'h00000000);
      check({31'h0, apb_e}, 32'h00000001);
      stop_test();
   end
endmodule
